// [rtl/mclk_nom_regs.sv]
// Master clock nominal frequency, adjust count and hold frequency register bank.
// Assumes an AXI4-Lite master and a DPLL and input block that read the field ports.
`timescale 1ns/1ns
module mclk_nom_regs (
  // Clock and reset
  input  wire logic                                   mclk,
  input  wire logic                                   nrst,
  // AXI4-Lite write address
  input  wire logic [mclk_nom_pkg::ADDR_W-1:0]        awaddr,
  input  wire logic [2:0]                             awprot,
  input  wire logic                                   awvalid,
  output logic                                        awready,
  // AXI4-Lite write data
  input  wire logic [mclk_nom_pkg::DATA_W-1:0]        wdata,
  input  wire logic [3:0]                             wstrb,
  input  wire logic                                   wvalid,
  output logic                                        wready,
  // AXI4-Lite write response
  output logic      [1:0]                             bresp,
  output logic                                        bvalid,
  input  wire logic                                   bready,
  // AXI4-Lite read address
  input  wire logic [mclk_nom_pkg::ADDR_W-1:0]        araddr,
  input  wire logic [2:0]                             arprot,
  input  wire logic                                   arvalid,
  output logic                                        arready,
  // AXI4-Lite read data
  output logic      [mclk_nom_pkg::DATA_W-1:0]        rdata,
  output logic      [1:0]                             rresp,
  output logic                                        rvalid,
  input  wire logic                                   rready,
  // Fields to DPLL and input block
  output logic      [mclk_nom_pkg::DPLL_NOM_W-1:0]    dpll_nominal_freq,
  output logic      [mclk_nom_pkg::INPUT_NOM_W-1:0]   input_nominal_freq,
  output logic      [mclk_nom_pkg::ADJUST_W-1:0]      adjust_count,
  output logic      [mclk_nom_pkg::HOLD_W-1:0]        hold_freq
);

  // Word index from a byte address; low two bits ignored
  function automatic mclk_nom_pkg::reg_idx_t idx_of(input logic [mclk_nom_pkg::ADDR_W-1:0] a);
    idx_of = a[mclk_nom_pkg::ADDR_W-1:mclk_nom_pkg::IDX_LSB];
  endfunction

  // Whether an index names a register of this bank
  function automatic logic is_mapped(input mclk_nom_pkg::reg_idx_t i);
    is_mapped = (i >= mclk_nom_pkg::DPLL_NOM_B0_IDX && i <= mclk_nom_pkg::ADJUST_HI_IDX) ||
                (i == mclk_nom_pkg::HOLD_STATUS_IDX) ||
                (i >= mclk_nom_pkg::HOLD_B0_IDX && i <= mclk_nom_pkg::HOLD_B3_IDX);
  endfunction

  // Captured write request
  logic                                   aw_held;
  logic                                   w_held;
  logic [mclk_nom_pkg::ADDR_W-1:0]        aw_addr_q;
  logic [mclk_nom_pkg::DATA_W-1:0]        w_data_q;
  logic                                   w_lane0_q;

  // Hold sub-block results
  logic [mclk_nom_pkg::HOLD_W-1:0]        hold_snapshot;
  logic                                   hold_pending;

  // Handshake decode
  wire aw_fire = awvalid && awready;
  wire w_fire  = wvalid && wready;
  wire b_fire  = bvalid && bready;
  wire ar_fire = arvalid && arready;
  wire r_fire  = rvalid && rready;

  // Write decode
  wire                                    do_write = aw_held && w_held && !bvalid;
  wire mclk_nom_pkg::reg_idx_t            wr_idx   = idx_of(aw_addr_q);
  wire                                    wr_ok    = is_mapped(wr_idx);
  wire                                    wr_en    = do_write && wr_ok && w_lane0_q;
  wire [mclk_nom_pkg::BYTE_W-1:0]         wr_byte  = w_data_q[mclk_nom_pkg::BYTE_W-1:0];

  wire wr_dn0 = wr_en && (wr_idx == mclk_nom_pkg::DPLL_NOM_B0_IDX);
  wire wr_dn1 = wr_en && (wr_idx == mclk_nom_pkg::DPLL_NOM_B1_IDX);
  wire wr_dn2 = wr_en && (wr_idx == mclk_nom_pkg::DPLL_NOM_B2_IDX);
  wire wr_dn3 = wr_en && (wr_idx == mclk_nom_pkg::DPLL_NOM_B3_IDX);
  wire wr_in0 = wr_en && (wr_idx == mclk_nom_pkg::INPUT_NOM_B0_IDX);
  wire wr_in1 = wr_en && (wr_idx == mclk_nom_pkg::INPUT_NOM_B1_IDX);
  wire wr_in2 = wr_en && (wr_idx == mclk_nom_pkg::INPUT_NOM_B2_IDX);
  wire wr_ac0 = wr_en && (wr_idx == mclk_nom_pkg::ADJUST_LO_IDX);
  wire wr_ac1 = wr_en && (wr_idx == mclk_nom_pkg::ADJUST_HI_IDX);
  wire wr_hf  = wr_en && (wr_idx >= mclk_nom_pkg::HOLD_B0_IDX) && (wr_idx <= mclk_nom_pkg::HOLD_B3_IDX);
  wire [1:0] wr_hf_byte = wr_idx[1:0];

  // Next field values; top bytes keep only their defined bits
  wire [mclk_nom_pkg::DPLL_NOM_W-1:0] next_dpll_nominal = {
    wr_dn3 ? wr_byte[mclk_nom_pkg::DPLL_TOP_W-1:0] : dpll_nominal_freq[25:24],
    wr_dn2 ? wr_byte : dpll_nominal_freq[23:16],
    wr_dn1 ? wr_byte : dpll_nominal_freq[15:8],
    wr_dn0 ? wr_byte : dpll_nominal_freq[7:0]
  };
  wire [mclk_nom_pkg::INPUT_NOM_W-1:0] next_input_nominal = {
    wr_in2 ? wr_byte[0] : input_nominal_freq[16],
    wr_in1 ? wr_byte : input_nominal_freq[15:8],
    wr_in0 ? wr_byte : input_nominal_freq[7:0]
  };
  wire [mclk_nom_pkg::ADJUST_W-1:0] next_adjust_count = {
    wr_ac1 ? wr_byte[0] : adjust_count[8],
    wr_ac0 ? wr_byte : adjust_count[7:0]
  };

  // Read decode
  wire mclk_nom_pkg::reg_idx_t            rd_idx  = idx_of(araddr);
  wire                                    rd_ok   = is_mapped(rd_idx);
  wire                                    snap_take = ar_fire && (rd_idx == mclk_nom_pkg::HOLD_B0_IDX);

  // Hold bytes above b0 come from the snapshot taken at the b0 read
  wire [mclk_nom_pkg::BYTE_W-1:0] rd_byte =
    (rd_idx == mclk_nom_pkg::DPLL_NOM_B0_IDX)  ? dpll_nominal_freq[7:0] :
    (rd_idx == mclk_nom_pkg::DPLL_NOM_B1_IDX)  ? dpll_nominal_freq[15:8] :
    (rd_idx == mclk_nom_pkg::DPLL_NOM_B2_IDX)  ? dpll_nominal_freq[23:16] :
    (rd_idx == mclk_nom_pkg::DPLL_NOM_B3_IDX)  ? {6'h00, dpll_nominal_freq[25:24]} :
    (rd_idx == mclk_nom_pkg::INPUT_NOM_B0_IDX) ? input_nominal_freq[7:0] :
    (rd_idx == mclk_nom_pkg::INPUT_NOM_B1_IDX) ? input_nominal_freq[15:8] :
    (rd_idx == mclk_nom_pkg::INPUT_NOM_B2_IDX) ? {7'h00, input_nominal_freq[16]} :
    (rd_idx == mclk_nom_pkg::ADJUST_LO_IDX)    ? adjust_count[7:0] :
    (rd_idx == mclk_nom_pkg::ADJUST_HI_IDX)    ? {7'h00, adjust_count[8]} :
    (rd_idx == mclk_nom_pkg::HOLD_STATUS_IDX)  ? {7'h00, hold_pending} :
    (rd_idx == mclk_nom_pkg::HOLD_B0_IDX)      ? hold_freq[7:0] :
    (rd_idx == mclk_nom_pkg::HOLD_B1_IDX)      ? hold_snapshot[15:8] :
    (rd_idx == mclk_nom_pkg::HOLD_B2_IDX)      ? hold_snapshot[23:16] :
    (rd_idx == mclk_nom_pkg::HOLD_B3_IDX)      ? hold_snapshot[31:24] :
    8'h00;
  wire [mclk_nom_pkg::DATA_W-1:0] rd_word = {24'h000000, rd_byte};

  // Write address channel
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      awready   <= 1'b1;
      aw_held   <= 1'b0;
      aw_addr_q <= 12'h000;
    end else if (aw_fire) begin
      awready   <= 1'b0;
      aw_held   <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (b_fire) begin
      awready   <= 1'b1;
      aw_held   <= 1'b0;
    end
  end

  // Write data channel
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wready    <= 1'b1;
      w_held    <= 1'b0;
      w_data_q  <= mclk_nom_pkg::DATA_ZERO;
      w_lane0_q <= 1'b0;
    end else if (w_fire) begin
      wready    <= 1'b0;
      w_held    <= 1'b1;
      w_data_q  <= wdata;
      w_lane0_q <= wstrb[0];
    end else if (b_fire) begin
      wready    <= 1'b1;
      w_held    <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bvalid <= 1'b0;
      bresp  <= mclk_nom_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? mclk_nom_pkg::RESP_OKAY : mclk_nom_pkg::RESP_SLVERR;
    end else if (b_fire) begin
      bvalid <= 1'b0;
    end
  end

  // Field storage
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dpll_nominal_freq  <= mclk_nom_pkg::DPLL_NOM_RST;
      input_nominal_freq <= mclk_nom_pkg::INPUT_NOM_RST;
      adjust_count       <= mclk_nom_pkg::ADJUST_RST;
    end else begin
      dpll_nominal_freq  <= next_dpll_nominal;
      input_nominal_freq <= next_input_nominal;
      adjust_count       <= next_adjust_count;
    end
  end

  // Read channel; no read side effects apart from the hold snapshot
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= mclk_nom_pkg::DATA_ZERO;
      rresp   <= mclk_nom_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word;
      rresp   <= rd_ok ? mclk_nom_pkg::RESP_OKAY : mclk_nom_pkg::RESP_SLVERR;
    end else if (r_fire) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

  // Hold value passes raw to the DPLL, which applies the ratio scaling
  hold_freq_stage u_hold (
    .mclk      (mclk),
    .nrst      (nrst),
    .wr_en     (wr_hf),
    .wr_byte   (wr_hf_byte),
    .wr_data   (wr_byte),
    .snap_take (snap_take),
    .hold_freq (hold_freq),
    .snapshot  (hold_snapshot),
    .pending   (hold_pending)
  );

endmodule // mclk_nom_regs

// [rtl/mclk_nom_pkg.sv]
// Constants for the master clock nominal, adjust count and hold frequency bank.
// Assumes byte registers sit one per aligned 32-bit word on an AXI4-Lite bus.
package mclk_nom_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned IDX_W    = 10;
  localparam int unsigned IDX_LSB  = 2;
  localparam int unsigned BYTE_W   = 8;

  typedef logic [IDX_W-1:0]  reg_idx_t;
  typedef logic [BYTE_W-1:0] reg_byte_t;

  // Register indices; byte address is four times the index
  localparam reg_idx_t DPLL_NOM_B0_IDX  = 10'h090;
  localparam reg_idx_t DPLL_NOM_B1_IDX  = 10'h091;
  localparam reg_idx_t DPLL_NOM_B2_IDX  = 10'h092;
  localparam reg_idx_t DPLL_NOM_B3_IDX  = 10'h093;
  localparam reg_idx_t INPUT_NOM_B0_IDX = 10'h094;
  localparam reg_idx_t INPUT_NOM_B1_IDX = 10'h095;
  localparam reg_idx_t INPUT_NOM_B2_IDX = 10'h096;
  localparam reg_idx_t ADJUST_LO_IDX    = 10'h097;
  localparam reg_idx_t ADJUST_HI_IDX    = 10'h098;
  localparam reg_idx_t HOLD_STATUS_IDX  = 10'h09A;
  localparam reg_idx_t HOLD_B0_IDX      = 10'h09C;
  localparam reg_idx_t HOLD_B1_IDX      = 10'h09D;
  localparam reg_idx_t HOLD_B2_IDX      = 10'h09E;
  localparam reg_idx_t HOLD_B3_IDX      = 10'h09F;

  // Field widths
  localparam int unsigned DPLL_NOM_W  = 26;
  localparam int unsigned INPUT_NOM_W = 17;
  localparam int unsigned ADJUST_W    = 9;
  localparam int unsigned HOLD_W      = 32;
  localparam int unsigned DPLL_TOP_W  = 2;

  // Reset values; zero nominal means 204.8 MHz
  localparam logic [DPLL_NOM_W-1:0]  DPLL_NOM_RST  = 26'h0000000;
  localparam logic [INPUT_NOM_W-1:0] INPUT_NOM_RST = 17'h00000;
  localparam logic [ADJUST_W-1:0]    ADJUST_RST    = 9'h000;
  localparam logic [HOLD_W-1:0]      HOLD_RST      = 32'h00000000;
  localparam int unsigned NOMINAL_RESET_HZ = 204800000;
  localparam int unsigned INPUT_NOM_STEP_HZ = 500;

  // Hold status fields
  localparam int unsigned STAT_PENDING_BIT = 0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;

endpackage

// [rtl/hold_freq_stage.sv]
// Staging, commit and read snapshot for the 32-bit hold frequency.
// Assumes byte writes and reads arrive in order b0 first, b3 last.
`timescale 1ns/1ns
module hold_freq_stage (
  // Clock and reset
  input  wire logic                             mclk,
  input  wire logic                             nrst,
  // Byte write
  input  wire logic                             wr_en,
  input  wire logic [1:0]                       wr_byte,
  input  wire logic [mclk_nom_pkg::BYTE_W-1:0]  wr_data,
  // Read snapshot
  input  wire logic                             snap_take,
  // Results
  output logic      [mclk_nom_pkg::HOLD_W-1:0]  hold_freq,
  output logic      [mclk_nom_pkg::HOLD_W-1:0]  snapshot,
  output logic                                  pending
);

  logic [23:0]                      stage;
  wire                              commit = wr_en && (wr_byte == 2'h3);
  wire                              partial = wr_en && (wr_byte != 2'h3);
  wire [mclk_nom_pkg::HOLD_W-1:0]   next_hold = {wr_data, stage};
  wire [23:0]                       next_stage = (wr_byte == 2'h0) ? {stage[23:8], wr_data} :
                                                 (wr_byte == 2'h1) ? {stage[23:16], wr_data, stage[7:0]} :
                                                 {wr_data, stage[15:0]};

  // Low bytes wait in the stage so the DPLL never sees a torn value
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stage     <= 24'h000000;
      hold_freq <= mclk_nom_pkg::HOLD_RST;
      pending   <= 1'b0;
    end else begin
      if (partial) begin
        stage <= next_stage;
      end
      if (commit) begin
        hold_freq <= next_hold;
      end
      pending <= partial ? 1'b1 : (commit ? 1'b0 : pending);
    end
  end

  // Upper bytes read from the copy frozen at the b0 read
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      snapshot <= mclk_nom_pkg::HOLD_RST;
    end else if (snap_take) begin
      // Same committed value that byte 0 returns, even if a commit lands now
      snapshot <= hold_freq;
    end
  end

endmodule // hold_freq_stage

// [verif/mclk_nom_regs_checker.sv]
// Port assertions for the nominal, adjust and hold register bank.
// Assumes one clock domain; bound onto mclk_nom_regs below.
`timescale 1ns/1ns
module mclk_nom_regs_checker (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        nrst,
  // Bus
  input wire logic [11:0] awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  // Fields
  input wire logic [25:0] dpll_nominal_freq,
  input wire logic [16:0] input_nominal_freq,
  input wire logic [8:0]  adjust_count,
  input wire logic [31:0] hold_freq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  // Fields move only as their own write completes
  property p_dpll;
    $changed(dpll_nominal_freq) |-> $rose(bvalid) && $past(awaddr[11:2], 2) inside {[10'h090:10'h093]};
  endproperty
  a_dpll: assert property (p_dpll) else $error("dpll field moved");
  property p_inp;
    $changed(input_nominal_freq) |-> $rose(bvalid) && $past(awaddr[11:2], 2) inside {[10'h094:10'h096]};
  endproperty
  a_inp: assert property (p_inp) else $error("input field moved");
  property p_adj;
    $changed(adjust_count) |-> $rose(bvalid) && $past(awaddr[11:2], 2) inside {[10'h097:10'h098]};
  endproperty
  a_adj: assert property (p_adj) else $error("adjust field moved");
  // Hold changes only on the last byte, all at once
  property p_hold;
    $changed(hold_freq) |-> $rose(bvalid) && $past(awaddr[11:2], 2) == 10'h09F;
  endproperty
  a_hold: assert property (p_hold) else $error("hold moved early");
  property p_upper;
    rvalid |-> rdata[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper) else $error("read upper bits set");
  property p_bans;
    awvalid && awready && wvalid && wready |=> ##1 bvalid;
  endproperty
  a_bans: assert property (p_bans) else $error("write answer late");
  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    rvalid && !rready |=> rvalid ##0 $stable(rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data unstable");
endmodule // mclk_nom_regs_checker
bind mclk_nom_regs mclk_nom_regs_checker mclk_nom_regs_checker_inst (.mclk, .nrst, .awaddr, .awvalid, .awready,
  .wvalid, .wready, .bresp, .bvalid, .bready, .rdata, .rvalid, .rready, .dpll_nominal_freq, .input_nominal_freq,
  .adjust_count, .hold_freq);

// [verif/tb_mclk_nom_regs.sv]
// Self-checking bench for the nominal, adjust and hold register bank.
// Assumes the checker binds itself; the bench is the AXI4-Lite master.
`timescale 1ns/1ns
module tb_mclk_nom_regs;
  logic        mclk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000, rdata, hold_freq;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp;
  logic [25:0] dpll_nominal_freq;
  logic [16:0] input_nominal_freq;
  logic [8:0]  adjust_count;
  int          mismatches = 0, comparisons = 0;
  mclk_nom_regs mclk_nom_regs_inst (.mclk, .nrst, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .dpll_nominal_freq, .input_nominal_freq, .adjust_count, .hold_freq);
  always #25 mclk = ~mclk;
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Channel select: 0 write request, 1 write answer, 2 read request, 3 read answer
  function automatic logic hs_ok(input int ch);
    case (ch)
      0: return awready && wready;
      1: return bvalid && bready;
      2: return arready && arvalid;
      default: return rvalid && rready;
    endcase
  endfunction
  // Bounded wait; a hung handshake ends the run
  task automatic hs(input int ch);
    int n = 0;
    do @(posedge mclk); while (!hs_ok(ch) && ++n < 64);
    if (!hs_ok(ch)) begin
      mismatches++;
      finish_test();
    end
  endtask
  // Upper data and strobe bits carry junk on purpose
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic s, input logic [1:0] er, input int lag);
    @(posedge mclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'hA5C3E1, d};
    wstrb <= {3'h7, s};
    {awvalid, wvalid} <= 2'h3;
    hs(0);
    {awvalid, wvalid} <= 2'h0;
    repeat (lag) @(posedge mclk);
    bready <= 1'b1;
    hs(1);
    bready <= 1'b0;
    check(32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er, input int lag);
    @(posedge mclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    hs(2);
    arvalid <= 1'b0;
    repeat (lag) @(posedge mclk);
    rready <= 1'b1;
    hs(3);
    rready <= 1'b0;
    check(rdata, exp);
    check(32'(rresp), 32'(er));
  endtask
  function automatic int rnd(input real v);
    return $rtoi(v < 0.0 ? v - 0.5 : v + 0.5);
  endfunction
  task automatic t_reset_refuse();
    for (int k = 'h90; k <= 'h9F; k++) if (k < 'h99 || k > 'h9B) rd(10'(k), 32'h00000000, 2'h0, k % 3);
    check(32'(dpll_nominal_freq), 32'h00000000);
    check(32'(input_nominal_freq), 32'h00000000);
    check(32'(adjust_count), 32'h00000000);
    wr(10'h000, 8'h5A, 1'b1, mclk_nom_pkg::RESP_SLVERR, 1);
    rd(10'h3FF, 32'h00000000, mclk_nom_pkg::RESP_SLVERR, 0);
    wr(10'h090, 8'h3C, 1'b0, 2'h0, 0);
    check(32'(dpll_nominal_freq), 32'h00000000);
  endtask
  task automatic t_nominal();
    real f[2] = '{200.0e6, 208.333e6};
    int d;
    int i;
    foreach (f[k]) begin
      d = rnd((204.8e6 / f[k] - 1.0) * 1.0e6 / 0.002452866);
      i = rnd((204.8e6 - f[k]) / 500.0);
      for (int b = 0; b < 4; b++) wr(10'h090 + 10'(b), d[8*b +: 8], 1'b1, 2'h0, b);
      for (int b = 0; b < 3; b++) wr(10'h094 + 10'(b), i[8*b +: 8], 1'b1, 2'h0, 0);
      check(32'(dpll_nominal_freq), 32'(d[25:0]));
      check(32'(input_nominal_freq), 32'(i[16:0]));
      rd(10'h093, 32'(d[25:24]), 2'h0, 2);
      rd(10'h096, 32'(i[16]), 2'h0, 0);
    end
  endtask
  task automatic t_adjust();
    real q;
    int a[3];
    q = 2.0e6 / (0.002452866 * rnd(190.0e6 / 500.0)) - 1991.0;
    a = '{rnd(q), rnd(q / 16.0), -1};
    foreach (a[k]) begin
      wr(10'h097, a[k][7:0], 1'b1, 2'h0, 0);
      wr(10'h098, a[k][15:8], 1'b1, 2'h0, 1);
      check(32'(adjust_count), 32'(a[k][8:0]));
      rd(10'h098, 32'(a[k][8]), 2'h0, 0);
    end
  endtask
  // Old snapshot must survive a full rewrite between byte reads
  task automatic t_hold();
    logic [31:0] v = 32'h812345F6;
    logic [31:0] w = 32'h7EDCBA09;
    for (int b = 0; b < 3; b++) wr(10'h09C + 10'(b), v[8*b +: 8], 1'b1, 2'h0, 0);
    check(hold_freq, 32'h00000000);
    rd(10'h09A, 32'h00000001, 2'h0, 0);
    wr(10'h09F, v[31:24], 1'b1, 2'h0, 2);
    check(hold_freq, v);
    rd(10'h09A, 32'h00000000, 2'h0, 0);
    // Enable bit lives outside this bank, so the bank refuses it
    wr(10'h205, 8'h01, 1'b1, mclk_nom_pkg::RESP_SLVERR, 0);
    check(hold_freq, v);
    rd(10'h09C, 32'(v[7:0]), 2'h0, 0);
    for (int b = 0; b < 4; b++) wr(10'h09C + 10'(b), w[8*b +: 8], 1'b1, 2'h0, 0);
    check(hold_freq, w);
    for (int b = 1; b < 4; b++) rd(10'h09C + 10'(b), 32'(v[8*b +: 8]), 2'h0, 1);
    for (int b = 0; b < 4; b++) rd(10'h09C + 10'(b), 32'(w[8*b +: 8]), 2'h0, 0);
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    t_reset_refuse();
    t_nominal();
    t_adjust();
    t_hold();
    finish_test();
  end
endmodule // tb_mclk_nom_regs
